//--- rtl/ascale_pkg.sv
// constants and types shared by the analog scaling curve block
package ascale_pkg;
  localparam int NUM_CURVES = 4;
  localparam int NUM_SRC = 42;
  localparam int NUM_PTS = 20;
  localparam int DW = 32;
  localparam int FRAC = 8;
  localparam int STEP_W = 21;
  // timing: one step of cycle and time constant
  localparam int CLK_HZ = 200_000_000;
  localparam int STEP_MS = 5;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam int CYC_DEF_MS = 150;
  localparam int CYC_MAX_MS = 10_000;
  localparam int TAU_DEF_MS = 1000;
  localparam logic [STEP_W-1:0] CYC_DEF = STEP_W'(CYC_DEF_MS / STEP_MS);
  localparam logic [STEP_W-1:0] CYC_MAX = STEP_W'(CYC_MAX_MS / STEP_MS);
  localparam logic [STEP_W-1:0] TAU_DEF = STEP_W'(TAU_DEF_MS / STEP_MS);
  // register offsets inside one curve window
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TAU = 8'h04;
  localparam logic [7:0] OFF_CYC = 8'h08;
  localparam logic [7:0] OFF_MIN = 8'h0C;
  localparam logic [7:0] OFF_MAX = 8'h10;
  localparam logic [7:0] OFF_INPUT = 8'h14;
  localparam logic [7:0] OFF_OUTPUT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_USED = 8'h20;
  localparam logic [5:0] WRD_PX = 6'h10;
  localparam logic [5:0] WRD_PY = 6'h24;
  // control fields
  localparam int CTL_IN_EN = 0;
  localparam int CTL_CV_EN = 1;
  localparam int CTL_FILT = 2;
  localparam int CTL_OOR = 3;
  localparam int CTL_RND = 4;
  localparam int CTL_SRC = 8;
  localparam logic [DW-1:0] CTRL_MASK = 32'h0000_3F3F;
  localparam logic [DW-1:0] RST_CTRL = 32'h0000_0000;
  localparam logic [DW-1:0] RST_X2 = 32'h0000_0100;
  localparam logic [DW-1:0] FRAC_MASK = 32'h0000_00FF;
  localparam logic [DW-1:0] FRAC_HALF = 32'h0000_0080;
  typedef enum logic [1:0] {RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAREST} round_t;
  typedef struct packed {
    logic valid;
    logic signed [DW-1:0] value;
  } meas_t;
endpackage

//--- rtl/analog_input_scaling_curves.sv
// four analog scaling curves with wishbone register access
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling_curves #(
  parameter int STEP_CYCLES = ascale_pkg::STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire ascale_pkg::meas_t meas_i [ascale_pkg::NUM_SRC],
  output logic [ascale_pkg::NUM_CURVES-1:0] curve_out_of_range_flag_o,
  output logic [ascale_pkg::DW-1:0] curve_value_o [ascale_pkg::NUM_CURVES]
);
  localparam int NC = ascale_pkg::NUM_CURVES;
  localparam int NP = ascale_pkg::NUM_PTS;
  localparam int DW = ascale_pkg::DW;
  localparam int SW = ascale_pkg::STEP_W;
  localparam logic [31:0] TICK_LAST = 32'(STEP_CYCLES - 1);
  typedef enum logic [2:0] {E_IDLE, E_LOAD, E_FILT, E_SRCH, E_CALC, E_ROUND} eng_t;
  // configuration
  logic [DW-1:0] ctrl_reg [NC];
  logic [SW-1:0] tau_reg [NC], cyc_reg [NC];
  logic signed [DW-1:0] min_reg [NC], max_reg [NC];
  logic [NP-1:0] used_reg [NC];
  logic signed [DW-1:0] px_reg [NC][NP], py_reg [NC][NP];
  // state
  logic signed [DW-1:0] in_reg [NC], out_reg [NC];
  logic [NC-1:0] oor_reg, primed_reg, pend_reg, run;
  logic [31:0] tick_reg;
  logic tick;
  // bus
  logic ack_reg, wr;
  logic [1:0] acurve;
  logic [7:0] aoff;
  logic [5:0] pxi, pyi;
  logic [DW-1:0] rdata;
  // engine
  eng_t st_reg;
  logic [1:0] cur_reg, pick;
  logic take, lo_f_reg, hi_f_reg;
  logic signed [DW-1:0] raw_reg, v_reg, res_reg;
  logic [4:0] idx_reg, lo_reg, hi_reg;
  logic signed [DW-1:0] filt_next, res_next, rnd_next;
  logic [5:0] src;

  // byte-lane merge of write data under the select mask
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] d,
                                          input logic [3:0] s);
    logic [DW-1:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction
  // bus decode
  assign acurve = adr_i[9:8];
  assign aoff = {adr_i[7:2], 2'b00};
  assign pxi = adr_i[7:2] - ascale_pkg::WRD_PX;
  assign pyi = adr_i[7:2] - ascale_pkg::WRD_PY;
  assign wr = cyc_i & stb_i & we_i & ack_reg;
  assign ack_o = ack_reg;

  // ack one cycle after request, dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    rdata = '0;
    case (aoff)
      ascale_pkg::OFF_CTRL: rdata = ctrl_reg[acurve];
      ascale_pkg::OFF_TAU: rdata = 32'(tau_reg[acurve]);
      ascale_pkg::OFF_CYC: rdata = 32'(cyc_reg[acurve]);
      ascale_pkg::OFF_MIN: rdata = min_reg[acurve];
      ascale_pkg::OFF_MAX: rdata = max_reg[acurve];
      ascale_pkg::OFF_INPUT: rdata = in_reg[acurve];
      ascale_pkg::OFF_OUTPUT: rdata = out_reg[acurve];
      ascale_pkg::OFF_STAT: rdata = {30'h0, primed_reg[acurve], oor_reg[acurve]};
      ascale_pkg::OFF_USED: rdata = 32'(used_reg[acurve] | 20'h00003);
      default: begin
        if (pxi < 6'(NP)) begin
          rdata = px_reg[acurve][pxi[4:0]];
        end else if (pyi < 6'(NP)) begin
          rdata = py_reg[acurve][pyi[4:0]];
        end
      end
    endcase
  end

  // read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (cyc_i & stb_i & ~ack_reg) begin
      dat_o <= we_i ? '0 : rdata;
    end
  end

  // base step tick every 5 ms
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_reg == TICK_LAST);

  // pick lowest pending curve
  always_comb begin
    pick = 2'h0;
    for (int c = NC - 1; c >= 0; c--) begin
      if (pend_reg[c]) begin
        pick = 2'(c);
      end
    end
  end
  assign take = (st_reg == E_IDLE) && (|pend_reg);

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : gc
      logic [SW-1:0] cnt_reg;
      logic [DW-1:0] cw;
      assign run[g] = ctrl_reg[g][ascale_pkg::CTL_IN_EN]
                    & ctrl_reg[g][ascale_pkg::CTL_CV_EN];
      assign cw = merge(32'(cyc_reg[g]), dat_i, sel_i);
      assign curve_out_of_range_flag_o[g] = oor_reg[g];
      assign curve_value_o[g] = out_reg[g];

      // configuration writes for this curve
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_reg[g] <= ascale_pkg::RST_CTRL;
          tau_reg[g] <= ascale_pkg::TAU_DEF;
          cyc_reg[g] <= ascale_pkg::CYC_DEF;
          min_reg[g] <= '0;
          max_reg[g] <= '0;
          used_reg[g] <= '0;
          for (int p = 0; p < NP; p++) begin
            px_reg[g][p] <= (p == 1) ? ascale_pkg::RST_X2 : '0;
            py_reg[g][p] <= '0;
          end
        end else if (wr && acurve == 2'(g)) begin
          case (aoff)
            ascale_pkg::OFF_CTRL: begin
              ctrl_reg[g] <= merge(ctrl_reg[g], dat_i, sel_i) & ascale_pkg::CTRL_MASK;
            end
            ascale_pkg::OFF_TAU: tau_reg[g] <= SW'(merge(32'(tau_reg[g]), dat_i, sel_i));
            ascale_pkg::OFF_CYC: begin
              if (cw == '0) begin
                cyc_reg[g] <= SW'(1);
              end else if (cw > 32'(ascale_pkg::CYC_MAX)) begin
                cyc_reg[g] <= ascale_pkg::CYC_MAX;
              end else begin
                cyc_reg[g] <= SW'(cw);
              end
            end
            ascale_pkg::OFF_MIN: min_reg[g] <= merge(min_reg[g], dat_i, sel_i);
            ascale_pkg::OFF_MAX: max_reg[g] <= merge(max_reg[g], dat_i, sel_i);
            ascale_pkg::OFF_USED: begin
              used_reg[g] <= NP'(merge(32'(used_reg[g]), dat_i, sel_i));
            end
            default: begin
              if (pxi < 6'(NP)) begin
                px_reg[g][pxi[4:0]] <= merge(px_reg[g][pxi[4:0]], dat_i, sel_i);
              end else if (pyi < 6'(NP)) begin
                py_reg[g][pyi[4:0]] <= merge(py_reg[g][pyi[4:0]], dat_i, sel_i);
              end
            end
          endcase
        end
      end

      // update cycle counter, request wins over the engine's clear
      always_ff @(posedge clk_i) begin
        if (rst_i || !run[g]) begin
          cnt_reg <= '0;
          pend_reg[g] <= 1'b0;
        end else begin
          if (take && pick == 2'(g)) begin
            pend_reg[g] <= 1'b0;
          end
          if (tick) begin
            if (cnt_reg >= cyc_reg[g] - SW'(1)) begin
              cnt_reg <= '0;
              pend_reg[g] <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + SW'(1);
            end
          end
        end
      end
    end
  endgenerate

  // first-order low-pass step, gain cyc/(tau+cyc)
  always_comb begin
    logic signed [63:0] diff;
    logic signed [63:0] den;
    logic signed [63:0] q;
    diff = 64'(raw_reg) - 64'(in_reg[cur_reg]);
    den = 64'(tau_reg[cur_reg]) + 64'(cyc_reg[cur_reg]);
    q = (diff * $signed(64'(cyc_reg[cur_reg]))) / den; // signed so falling steps divide right
    filt_next = raw_reg;
    if (ctrl_reg[cur_reg][ascale_pkg::CTL_FILT] && primed_reg[cur_reg]) begin
      filt_next = in_reg[cur_reg] + DW'(q);
    end
  end

  // segment interpolation with end clamping
  always_comb begin
    logic signed [63:0] dx;
    logic signed [63:0] dy;
    logic signed [63:0] span;
    logic signed [63:0] q;
    dx = 64'(v_reg) - 64'(px_reg[cur_reg][lo_reg]);
    dy = 64'(py_reg[cur_reg][hi_reg]) - 64'(py_reg[cur_reg][lo_reg]);
    span = 64'(px_reg[cur_reg][hi_reg]) - 64'(px_reg[cur_reg][lo_reg]);
    q = (span == 64'h0) ? 64'h0 : (dx * dy) / span;
    if (!lo_f_reg) begin
      res_next = py_reg[cur_reg][hi_reg];
    end else if (!hi_f_reg) begin
      res_next = py_reg[cur_reg][lo_reg];
    end else begin
      res_next = py_reg[cur_reg][lo_reg] + DW'(q);
    end
  end

  // result rounding by handling code
  always_comb begin
    case (ascale_pkg::round_t'(ctrl_reg[cur_reg][ascale_pkg::CTL_RND +: 2]))
      ascale_pkg::RND_FLOOR: rnd_next = res_reg & ~ascale_pkg::FRAC_MASK;
      ascale_pkg::RND_CEIL: begin
        rnd_next = (res_reg + ascale_pkg::FRAC_MASK) & ~ascale_pkg::FRAC_MASK;
      end
      ascale_pkg::RND_NEAREST: begin
        rnd_next = (res_reg + ascale_pkg::FRAC_HALF) & ~ascale_pkg::FRAC_MASK;
      end
      default: rnd_next = res_reg;
    endcase
  end

  assign src = ctrl_reg[cur_reg][ascale_pkg::CTL_SRC +: 6];
  // engine sequence: load, filter, search, interpolate, round
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= E_IDLE;
      cur_reg <= '0;
      raw_reg <= '0;
      v_reg <= '0;
      res_reg <= '0;
      idx_reg <= '0;
      lo_reg <= '0;
      hi_reg <= '0;
      lo_f_reg <= 1'b0;
      hi_f_reg <= 1'b0;
    end else begin
      case (st_reg)
        E_IDLE: begin
          if (take) begin
            cur_reg <= pick;
            st_reg <= E_LOAD;
          end
        end
        E_LOAD: begin
          if (src < 6'(ascale_pkg::NUM_SRC) && meas_i[src].valid) begin
            raw_reg <= meas_i[src].value;
          end else begin
            raw_reg <= in_reg[cur_reg];
          end
          st_reg <= E_FILT;
        end
        E_FILT: begin
          v_reg <= filt_next;
          idx_reg <= '0;
          lo_reg <= '0;
          hi_reg <= '0;
          lo_f_reg <= 1'b0;
          hi_f_reg <= 1'b0;
          st_reg <= E_SRCH;
        end
        E_SRCH: begin
          if (idx_reg < 5'd2 || used_reg[cur_reg][idx_reg]) begin
            if (px_reg[cur_reg][idx_reg] <= v_reg) begin
              lo_reg <= idx_reg;
              lo_f_reg <= 1'b1;
            end else if (!hi_f_reg) begin
              hi_reg <= idx_reg;
              hi_f_reg <= 1'b1;
            end
          end
          if (idx_reg == 5'(NP - 1)) begin
            st_reg <= E_CALC;
          end else begin
            idx_reg <= idx_reg + 5'd1;
          end
        end
        E_CALC: begin
          res_reg <= res_next;
          st_reg <= E_ROUND;
        end
        E_ROUND: st_reg <= E_IDLE;
        default: st_reg <= E_IDLE;
      endcase
    end
  end

  // input indication, filter state and range flag per update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reg <= '{default: '0};
      oor_reg <= '0;
      primed_reg <= '0;
    end else if (st_reg == E_FILT) begin
      in_reg[cur_reg] <= filt_next;
      primed_reg[cur_reg] <= 1'b1;
      oor_reg[cur_reg] <= ctrl_reg[cur_reg][ascale_pkg::CTL_OOR]
                        & ((filt_next < min_reg[cur_reg])
                        | (filt_next > max_reg[cur_reg]));
    end
  end

  // scaled output indication
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= '{default: '0};
    end else if (st_reg == E_ROUND) begin
      out_reg[cur_reg] <= rnd_next;
    end
  end
endmodule
`default_nettype wire

//--- sim/scaling_monitor.sv
// concurrent checks on the scaling block ports
`timescale 1ns/100ps
`default_nettype none
module scaling_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [ascale_pkg::NUM_CURVES-1:0] curve_out_of_range_flag_o,
  input wire logic [ascale_pkg::DW-1:0] curve_value_o [ascale_pkg::NUM_CURVES]
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer timing
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data moved without access");
  // outputs cleared while reset is held
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !ack_o
      && curve_out_of_range_flag_o == 4'h0 && dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  // indications move at most once per update
  flag_hold_a: assert property ($changed(curve_out_of_range_flag_o[0]) |=>
      $stable(curve_out_of_range_flag_o[0]) [*8])
    else $error("flag changed twice in one update");
  value_hold_a: assert property ($changed(curve_value_o[0]) |=>
      $stable(curve_value_o[0]) [*8])
    else $error("output changed twice in one update");
  flag_order_a: assert property ($changed(curve_out_of_range_flag_o[0]) |->
      $stable(curve_value_o[0]))
    else $error("flag and output updated together");
endmodule
`default_nettype wire

//--- sim/meas_channels.sv
// measurement channel model feeding the source inputs
`timescale 1ns/100ps
`default_nettype none
module meas_channels (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic [5:0] src_i,
  input wire logic valid_i,
  input wire logic [31:0] value_i,
  output var ascale_pkg::meas_t meas_o [ascale_pkg::NUM_SRC]
);
  logic [32:0] store_reg [ascale_pkg::NUM_SRC];
  // latch a new reading for one channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ascale_pkg::NUM_SRC; i++) begin
        store_reg[i] <= 33'h1_0000_0000;
      end
    end else if (set_i) begin
      store_reg[src_i] <= {valid_i, value_i};
    end
  end
  // a lost channel shows garbage, not its last reading
  always_comb begin
    for (int i = 0; i < ascale_pkg::NUM_SRC; i++) begin
      meas_o[i].valid = store_reg[i][32];
      meas_o[i].value = store_reg[i][32] ? store_reg[i][31:0] : ~store_reg[i][31:0];
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_analog_input_scaling_curves.sv
// self-checking bench for the analog scaling curves
`timescale 1ns/100ps
`default_nettype none
module tb_analog_input_scaling_curves;
  typedef struct {
    logic [5:0] s;
    logic [31:0] v;
    logic [1:0] r;
    logic [31:0] o;
    logic f;
  } row_t;
  // source, reading, rounding, output, flag; curve 0..1.0 maps to 0..3.0
  row_t rows [7] = '{
    '{6'h00, 32'h0000_0060, 2'h0, 32'h0000_0120, 1'b0},
    '{6'h04, 32'h0000_0060, 2'h1, 32'h0000_0100, 1'b0},
    '{6'h18, 32'h0000_0060, 2'h2, 32'h0000_0200, 1'b0},
    '{6'h28, 32'h0000_0060, 2'h3, 32'h0000_0100, 1'b0},
    '{6'h29, 32'h0000_0200, 2'h0, 32'h0000_0300, 1'b1},
    '{6'h03, 32'hFFFF_FFC0, 2'h0, 32'h0000_0000, 1'b1},
    '{6'h00, 32'h0000_0100, 2'h0, 32'h0000_0300, 1'b0}};
  // register addresses and their reset values, last two an unmapped word and the read-only input
  logic [9:0] ra [10] = '{10'h000, 10'h004, 10'h008, 10'h00C, 10'h010, 10'h044,
    10'h090, 10'h020, 10'h0FC, 10'h014};
  logic [31:0] rv [10] = '{32'h0, 32'h0000_00C8, 32'h0000_001E, 32'h0, 32'h0,
    32'h0000_0100, 32'h0, 32'h0000_0003, 32'h0, 32'h0};
  logic clk_i, rst_i, cyc, stb, we, ack_o, set, valid;
  logic [9:0] adr;
  logic [3:0] sel, flag;
  logic [5:0] src;
  logic [31:0] wdat, rdat, dat_o, value;
  logic [31:0] cval [4];
  ascale_pkg::meas_t meas [ascale_pkg::NUM_SRC];
  int n_mismatch = 0;
  int n_tests = 0;
  int n_cyc;

  analog_input_scaling_curves #(.STEP_CYCLES(20)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .meas_i(meas), .curve_out_of_range_flag_o(flag),
    .curve_value_o(cval));
  meas_channels model (.clk_i(clk_i), .rst_i(rst_i), .set_i(set), .src_i(src),
    .valid_i(valid), .value_i(value), .meas_o(meas));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task timeout;
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict;
  endtask
  // one classic wishbone access, held until ack
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 40);
    if (k >= 40) timeout;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task feed(input logic [5:0] s, input logic ok, input logic [31:0] v);
    @(posedge clk_i);
    set <= 1'b1;
    src <= s;
    valid <= ok;
    value <= v;
    @(posedge clk_i);
    set <= 1'b0;
  endtask
  // covers one full update period of 40 clocks plus the engine run
  task settle;
    repeat (120) @(posedge clk_i);
  endtask
  // waits for the next output change, returns the clocks waited
  task wait_chg(output int n);
    logic [31:0] p;
    int k;
    p = cval[0];
    k = 0;
    while (cval[0] === p && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    n = k;
    if (k >= 200) timeout;
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    sel = 4'hF;
    wdat = 32'h0;
    set = 1'b0;
    src = 6'h00;
    valid = 1'b1;
    value = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 10'h008, 32'h2);
    wb(1'b1, 10'h010, 32'h100);
    wb(1'b1, 10'h094, 32'h300);
    foreach (rows[i]) begin
      feed(rows[i].s, 1'b1, rows[i].v);
      wb(1'b1, 10'h000, {18'h0, rows[i].s, 2'h0, rows[i].r, 4'hB});
      settle;
      wb(1'b0, 10'h014, 32'h0);
      chk(rdat, rows[i].v);
      wb(1'b0, 10'h018, 32'h0);
      chk(rdat, rows[i].o);
      chk(cval[0], rows[i].o);
      chk({31'h0, flag[0]}, {31'h0, rows[i].f});
      $display("row %0d done", i);
    end
    $display("table rows done");
    // lost signal, then a disabled curve, keep the last reading
    feed(6'h00, 1'b0, 32'h0000_0240);
    settle;
    wb(1'b0, 10'h014, 32'h0);
    chk(rdat, 32'h100);
    wb(1'b1, 10'h000, 32'h9);
    feed(6'h00, 1'b1, 32'h0000_0280);
    settle;
    wb(1'b0, 10'h014, 32'h0);
    chk(rdat, 32'h100);
    chk(cval[0], 32'h300);
    $display("hold cases done");
    // filtered step with time constant equal to the cycle halves each error
    // curve widened to 0..4.0 -> 0..4.0 so the filtered value is not clamped
    wb(1'b1, 10'h044, 32'h400);
    wb(1'b1, 10'h094, 32'h400);
    wb(1'b1, 10'h004, 32'h2);
    feed(6'h00, 1'b1, 32'h100);
    wb(1'b1, 10'h000, 32'h7);
    settle;
    feed(6'h00, 1'b1, 32'h300);
    wait_chg(n_cyc);
    chk(cval[0], 32'h200);
    wait_chg(n_cyc);
    chk(cval[0], 32'h280);
    // updates are 2 steps of 20 clocks apart
    chk(32'(n_cyc), 32'h0000_0028);
    $display("filter done");
    // second reset restores defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(cval[0], 32'h0);
    chk({28'h0, flag}, 32'h0);
    wb(1'b1, 10'h014, 32'h55);
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      chk(rdat, rv[i]);
    end
    // byte-lane write: only the low byte of the minimum takes the data
    sel <= 4'h1;
    wb(1'b1, 10'h00C, 32'hFFFF_FFFF);
    sel <= 4'hF;
    wb(1'b0, 10'h00C, 32'h0);
    chk(rdat, 32'h0000_00FF);
    $display("reset defaults done");
    give_verdict;
  end
endmodule

bind analog_input_scaling_curves scaling_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .curve_out_of_range_flag_o(curve_out_of_range_flag_o), .curve_value_o(curve_value_o));
`default_nettype wire
